// ==== include/rwcm_pkg.sv ====
// constants for the reset, watchdog and clock monitor block
// Contract
// - after power-up hold reset for 4064 clock cycles
// - if reset pin still low after that delay, stay in reset until high
// - on any sensed reset drive the reset pin low four cycles, then release
// - sample pin two cycles after release: low external, high internal
// - power-on and pin share the normal vector; watchdog, clock monitor own vectors
// - reset stops the core, initializes control bits, selects the vector
// - watchdog enable comes from setup register, taking effect after reset
// - disable bit 0 lets timeouts reset; 1 blocks timeout resets
// - special modes start with watchdog resets inhibited; writing 0 allows them
// - watchdog counts clock over 2^15, then over 1, 4, 16 or 64
// - rate field resets to 0, the shortest timeout
// - normal modes: rate written once within 64 cycles; special: any time
// - other bus traffic allowed between arm and clear writes
// - enabled watchdog resets the system on timeout without service
// - watchdog stops counting while the system clock is halted
// - clock monitor enabled and no clock edges within RC delay gives reset
// - below 10 kHz flagged, 200 kHz or more never flagged
// - clock monitor enable read/write any time, 0 after reset
// - halting with clock monitor enabled produces a reset
// - interrupt sense select: 0 level, 1 edge only
`default_nettype none
package rwcm_pkg;
  // register byte offsets
  localparam logic [7:0] RWCM_OFF_SERVICE = 8'h00;
  localparam logic [7:0] RWCM_OFF_OPTIONS = 8'h04;
  localparam logic [7:0] RWCM_OFF_SETUP = 8'h08;
  localparam logic [7:0] RWCM_OFF_TEST = 8'h0c;
  localparam logic [7:0] RWCM_OFF_STATUS = 8'h10;
  // decoded register index
  typedef enum logic [2:0] {
    RWCM_REG_SERVICE = 3'd0,
    RWCM_REG_OPTIONS = 3'd1,
    RWCM_REG_SETUP = 3'd2,
    RWCM_REG_TEST = 3'd3,
    RWCM_REG_STATUS = 3'd4,
    RWCM_REG_NONE = 3'd7
  } rwcm_reg_t;
  // field positions
  localparam int RWCM_OPT_EDGE_BIT = 5;
  localparam int RWCM_OPT_CME_BIT = 3;
  localparam int RWCM_SETUP_NOWDT_BIT = 2;
  localparam int RWCM_TEST_INHIBIT_BIT = 0;
  // reset values
  localparam logic [7:0] RWCM_SETUP_INIT = 8'h0f;
  localparam logic [1:0] RWCM_RATE_INIT = 2'b00;
  // service codes
  localparam logic [7:0] RWCM_ARM_CODE = 8'h55;
  localparam logic [7:0] RWCM_CLEAR_CODE = 8'haa;
  // timing counts in bus clock cycles
  localparam int RWCM_POR_CYCLES = 4064;
  localparam int RWCM_DRIVE_CYCLES = 4;
  localparam int RWCM_SETTLE_CYCLES = 2;
  localparam int RWCM_RATE_WINDOW = 64;
  localparam int RWCM_WDT_BASE_DIV = 32768;
  // reset causes
  typedef enum logic [1:0] {
    RWCM_CAUSE_POR = 2'd0,
    RWCM_CAUSE_PIN = 2'd1,
    RWCM_CAUSE_CLKMON = 2'd2,
    RWCM_CAUSE_WDT = 2'd3
  } rwcm_cause_t;
  // reset vectors
  localparam logic [15:0] RWCM_VEC_NORMAL = 16'hfffe;
  localparam logic [15:0] RWCM_VEC_CLKMON = 16'hfffc;
  localparam logic [15:0] RWCM_VEC_WDT = 16'hfffa;
  localparam logic [15:0] RWCM_VEC_SPECIAL_MASK = 16'hbfff;
  // bus responses
  localparam logic [1:0] RWCM_RESP_OKAY = 2'b00;
  localparam logic [1:0] RWCM_RESP_SLVERR = 2'b10;
  // reset sequencer states, gray in declaration order
  typedef enum logic [2:0] {
    RWCM_ST_POR = 3'b000,
    RWCM_ST_PINHOLD = 3'b001,
    RWCM_ST_RUN = 3'b011,
    RWCM_ST_DRIVE = 3'b010,
    RWCM_ST_SETTLE = 3'b110,
    RWCM_ST_EXTHOLD = 3'b111
  } rwcm_state_t;
endpackage : rwcm_pkg
`default_nettype wire

// ==== core/rwcm_top.sv ====
// reset sequencer, watchdog and clock monitor with an axi4-lite register slave
`default_nettype none
module rwcm_top
  import rwcm_pkg::*;
#(
  parameter int WDT_BASE_DIV = RWCM_WDT_BASE_DIV,
  parameter int POR_CYCLES = RWCM_POR_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic rst_pin_i,
  output logic rst_pin_o,
  output logic rst_pin_oe,
  input wire logic special_mode_i,
  input wire logic halt_i,
  input wire logic clk_fail_i,
  output logic sys_rst_o,
  output logic [15:0] reset_vector_o,
  output logic [1:0] reset_cause_o,
  output logic ext_int_edge_sel_o,
  output logic clock_monitor_en_o
);

  // address decode shared by the read and write paths
  function automatic rwcm_reg_t reg_decode(input logic [7:0] addr);
    if (addr == RWCM_OFF_SERVICE)
      reg_decode = RWCM_REG_SERVICE;
    else if (addr == RWCM_OFF_OPTIONS)
      reg_decode = RWCM_REG_OPTIONS;
    else if (addr == RWCM_OFF_SETUP)
      reg_decode = RWCM_REG_SETUP;
    else if (addr == RWCM_OFF_TEST)
      reg_decode = RWCM_REG_TEST;
    else if (addr == RWCM_OFF_STATUS)
      reg_decode = RWCM_REG_STATUS;
    else
      reg_decode = RWCM_REG_NONE;
  endfunction : reg_decode

  localparam logic [11:0] POR_LAST = 12'(POR_CYCLES - 1);
  localparam logic [2:0] DRIVE_LAST = 3'(RWCM_DRIVE_CYCLES - 1);
  localparam logic [2:0] SETTLE_LAST = 3'(RWCM_SETTLE_CYCLES - 1);
  localparam logic [6:0] WINDOW_END = 7'(RWCM_RATE_WINDOW);
  localparam logic [15:0] BASE_LAST = 16'(WDT_BASE_DIV - 1);

  rwcm_state_t state_r;
  logic [11:0] por_cnt_r;
  logic [2:0] seq_cnt_r;
  logic sys_rst_r;
  logic drive_r;
  rwcm_cause_t cause_r;
  rwcm_cause_t pend_cause_r;
  logic [15:0] vector_r;
  logic [7:0] setup_r;
  logic wdt_en_r;
  logic inhibit_r;
  logic [1:0] rate_r;
  logic rate_written_r;
  logic [6:0] win_cnt_r;
  logic cme_r;
  logic edge_sel_r;
  logic armed_r;
  logic [15:0] base_cnt_r;
  logic [6:0] scale_cnt_r;
  logic wdt_timeout;
  logic cm_fail;
  logic [6:0] scale_limit;

  // axi write and read channel state
  logic aw_held_r;
  logic w_held_r;
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic arready_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic wr_go;
  rwcm_reg_t wr_reg;
  rwcm_reg_t rd_reg;
  logic [7:0] wr_byte;
  logic wr_lane0;

  // write fires once both address and data are held and no response waits
  assign wr_go = aw_held_r && w_held_r && !bvalid_r;
  assign wr_reg = reg_decode(aw_addr_r);
  assign rd_reg = reg_decode(s_axi_araddr);
  assign wr_byte = w_data_r[7:0];
  assign wr_lane0 = w_strb_r[0];

  // address and data channels accepted independently
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_r <= 1'b0;
      aw_addr_r <= 8'h00;
    end
    else if (s_axi_awvalid && !aw_held_r)
    begin
      aw_held_r <= 1'b1;
      aw_addr_r <= s_axi_awaddr;
    end
    else if (wr_go)
      aw_held_r <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_held_r <= 1'b0;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
    end
    else if (s_axi_wvalid && !w_held_r)
    begin
      w_held_r <= 1'b1;
      w_data_r <= s_axi_wdata;
      w_strb_r <= s_axi_wstrb;
    end
    else if (wr_go)
      w_held_r <= 1'b0;
  end

  // write response, error for unmapped or read-only targets
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_r <= 1'b0;
      bresp_r <= RWCM_RESP_OKAY;
    end
    else if (wr_go)
    begin
      bvalid_r <= 1'b1;
      if (wr_reg == RWCM_REG_NONE || wr_reg == RWCM_REG_STATUS)
        bresp_r <= RWCM_RESP_SLVERR;
      else
        bresp_r <= RWCM_RESP_OKAY;
    end
    else if (s_axi_bready)
      bvalid_r <= 1'b0;
  end

  // read path, one cycle from address to data
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= RWCM_RESP_OKAY;
    end
    else if (s_axi_arvalid && arready_r)
    begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b1;
      rresp_r <= RWCM_RESP_OKAY;
      rdata_r <= 32'h0000_0000;
      if (rd_reg == RWCM_REG_OPTIONS)
      begin
        rdata_r[RWCM_OPT_EDGE_BIT] <= edge_sel_r;
        rdata_r[RWCM_OPT_CME_BIT] <= cme_r;
        rdata_r[1:0] <= rate_r;
      end
      else if (rd_reg == RWCM_REG_SETUP)
        rdata_r[7:0] <= setup_r;
      else if (rd_reg == RWCM_REG_TEST)
        rdata_r[RWCM_TEST_INHIBIT_BIT] <= inhibit_r;
      else if (rd_reg == RWCM_REG_STATUS)
        rdata_r[7:0] <= {2'b00, rate_written_r, armed_r, wdt_en_r, special_mode_i, cause_r};
      else if (rd_reg == RWCM_REG_NONE)
        rresp_r <= RWCM_RESP_SLVERR;
    end
    else if (rvalid_r && s_axi_rready)
    begin
      rvalid_r <= 1'b0;
      arready_r <= 1'b1;
    end
  end

  // reset sequencer
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_r <= RWCM_ST_POR;
      por_cnt_r <= 12'h000;
      seq_cnt_r <= 3'h0;
      sys_rst_r <= 1'b1;
      drive_r <= 1'b0;
      cause_r <= RWCM_CAUSE_POR;
      pend_cause_r <= RWCM_CAUSE_POR;
      vector_r <= RWCM_VEC_NORMAL;
    end
    else
    begin
      case (state_r)
        RWCM_ST_POR:
        begin
          por_cnt_r <= por_cnt_r + 12'h001;
          if (por_cnt_r == POR_LAST)
            state_r <= rst_pin_i ? RWCM_ST_RUN : RWCM_ST_PINHOLD;
          if (por_cnt_r == POR_LAST && rst_pin_i)
            sys_rst_r <= 1'b0;
        end
        RWCM_ST_PINHOLD:
        begin
          if (rst_pin_i)
          begin
            state_r <= RWCM_ST_RUN;
            sys_rst_r <= 1'b0;
          end
        end
        RWCM_ST_RUN:
        begin
          // pin before clock monitor before watchdog
          if (!rst_pin_i || cm_fail || wdt_timeout)
          begin
            state_r <= RWCM_ST_DRIVE;
            sys_rst_r <= 1'b1;
            drive_r <= 1'b1;
            seq_cnt_r <= 3'h0;
            pend_cause_r <= cm_fail ? RWCM_CAUSE_CLKMON : RWCM_CAUSE_WDT;
          end
        end
        RWCM_ST_DRIVE:
        begin
          seq_cnt_r <= seq_cnt_r + 3'h1;
          if (seq_cnt_r == DRIVE_LAST)
          begin
            state_r <= RWCM_ST_SETTLE;
            drive_r <= 1'b0;
            seq_cnt_r <= 3'h0;
          end
        end
        RWCM_ST_SETTLE:
        begin
          seq_cnt_r <= seq_cnt_r + 3'h1;
          if (seq_cnt_r == SETTLE_LAST)
          begin
            if (!rst_pin_i)
            begin
              state_r <= RWCM_ST_EXTHOLD;
              cause_r <= RWCM_CAUSE_PIN;
              vector_r <= RWCM_VEC_NORMAL;
            end
            else
            begin
              state_r <= RWCM_ST_RUN;
              sys_rst_r <= 1'b0;
              cause_r <= pend_cause_r;
              vector_r <= (pend_cause_r == RWCM_CAUSE_CLKMON) ? RWCM_VEC_CLKMON
                                                             : RWCM_VEC_WDT;
            end
          end
        end
        RWCM_ST_EXTHOLD:
        begin
          if (rst_pin_i)
          begin
            state_r <= RWCM_ST_RUN;
            sys_rst_r <= 1'b0;
          end
        end
        default:
        begin
          state_r <= RWCM_ST_POR;
          sys_rst_r <= 1'b1;
          drive_r <= 1'b0;
        end
      endcase
    end
  end

  // nonvolatile setup survives internal resets, reloaded with 0x0f only by power-on
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      setup_r <= RWCM_SETUP_INIT;
    else if (wr_go && wr_lane0 && wr_reg == RWCM_REG_SETUP)
      setup_r <= wr_byte;
  end

  // enable sampled from setup only while in reset
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      wdt_en_r <= 1'b0;
    else if (sys_rst_r)
      wdt_en_r <= !setup_r[RWCM_SETUP_NOWDT_BIT];
  end

  // test inhibit, set out of reset in special modes
  always_ff @(posedge aclk)
  begin
    if (!aresetn || sys_rst_r)
      inhibit_r <= special_mode_i;
    else if (wr_go && wr_lane0 && wr_reg == RWCM_REG_TEST && special_mode_i)
      inhibit_r <= wr_byte[RWCM_TEST_INHIBIT_BIT];
  end

  // options register, cleared by every reset
  always_ff @(posedge aclk)
  begin
    if (!aresetn || sys_rst_r)
    begin
      cme_r <= 1'b0;
      edge_sel_r <= 1'b0;
      rate_r <= RWCM_RATE_INIT;
      rate_written_r <= 1'b0;
    end
    else if (wr_go && wr_lane0 && wr_reg == RWCM_REG_OPTIONS)
    begin
      cme_r <= wr_byte[RWCM_OPT_CME_BIT];
      edge_sel_r <= wr_byte[RWCM_OPT_EDGE_BIT];
      if (special_mode_i || (!rate_written_r && win_cnt_r < WINDOW_END))
      begin
        rate_r <= wr_byte[1:0];
        rate_written_r <= !special_mode_i;
      end
    end
  end

  // cycles since reset release for the rate write window
  always_ff @(posedge aclk)
  begin
    if (!aresetn || sys_rst_r)
      win_cnt_r <= 7'h00;
    else if (win_cnt_r < WINDOW_END)
      win_cnt_r <= win_cnt_r + 7'h01;
  end

  // arm flag for the two-write service sequence
  always_ff @(posedge aclk)
  begin
    if (!aresetn || sys_rst_r)
      armed_r <= 1'b0;
    else if (wr_go && wr_lane0 && wr_reg == RWCM_REG_SERVICE)
    begin
      if (wr_byte == RWCM_ARM_CODE)
        armed_r <= 1'b1;
      else if (wr_byte == RWCM_CLEAR_CODE)
        armed_r <= 1'b0;
    end
  end

  // scale factor 1, 4, 16 or 64 from the rate code
  always_comb
  begin
    case (rate_r)
      2'b00: scale_limit = 7'd1;
      2'b01: scale_limit = 7'd4;
      2'b10: scale_limit = 7'd16;
      default: scale_limit = 7'd64;
    endcase
  end

  // free-running watchdog: base divider then scaled tick counter
  always_ff @(posedge aclk)
  begin
    if (!aresetn || sys_rst_r)
    begin
      base_cnt_r <= 16'h0000;
      scale_cnt_r <= 7'h00;
    end
    else if (wr_go && wr_lane0 && wr_reg == RWCM_REG_SERVICE &&
             wr_byte == RWCM_CLEAR_CODE && armed_r)
    begin
      base_cnt_r <= 16'h0000;
      scale_cnt_r <= 7'h00;
    end
    else if (!halt_i)
    begin
      if (base_cnt_r == BASE_LAST)
      begin
        base_cnt_r <= 16'h0000;
        if (scale_cnt_r < scale_limit)
          scale_cnt_r <= scale_cnt_r + 7'h01;
      end
      else
        base_cnt_r <= base_cnt_r + 16'h0001;
    end
  end

  // timeout reset unless disabled or inhibited
  assign wdt_timeout = wdt_en_r && !inhibit_r && (scale_cnt_r >= scale_limit);
  // rc detector flag or halted clock with monitor enabled
  assign cm_fail = cme_r && (clk_fail_i || halt_i);

  // outputs
  assign s_axi_awready = !aw_held_r;
  assign s_axi_wready = !w_held_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign rst_pin_o = 1'b0; // pin is only ever pulled low
  assign rst_pin_oe = drive_r;
  assign sys_rst_o = sys_rst_r;
  assign reset_vector_o = special_mode_i ? (vector_r & RWCM_VEC_SPECIAL_MASK) : vector_r;
  assign reset_cause_o = cause_r;
  assign ext_int_edge_sel_o = edge_sel_r;
  assign clock_monitor_en_o = cme_r;

endmodule : rwcm_top
`default_nettype wire

// ==== tb/rwcm_chk.sv ====
// checker for the reset sequencer, watchdog and clock monitor ports
`default_nettype none
module rwcm_chk
  import rwcm_pkg::*;
#(
  parameter int POR_CYCLES = RWCM_POR_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic rst_pin_i,
  input wire logic rst_pin_oe,
  input wire logic special_mode_i,
  input wire logic halt_i,
  input wire logic clk_fail_i,
  input wire logic sys_rst_o,
  input wire logic [15:0] reset_vector_o,
  input wire logic [1:0] reset_cause_o,
  input wire logic ext_int_edge_sel_o,
  input wire logic clock_monitor_en_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  logic [15:0] por_cnt_r;
  logic [15:0] vec_exp;
  // cycles since power-on release, saturating
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      por_cnt_r <= 16'h0000;
    else if (por_cnt_r != 16'hffff)
      por_cnt_r <= por_cnt_r + 16'h0001;
  end
  // vector expected from latched cause and mode
  assign vec_exp = (reset_cause_o == RWCM_CAUSE_WDT ? RWCM_VEC_WDT :
    reset_cause_o == RWCM_CAUSE_CLKMON ? RWCM_VEC_CLKMON : RWCM_VEC_NORMAL) &
    (special_mode_i ? RWCM_VEC_SPECIAL_MASK : 16'hffff);
  // pin released and seen high or low afterwards
  sequence s_rel_hi;
    $fell(rst_pin_oe) ##0 rst_pin_i [*3];
  endsequence
  sequence s_rel_lo;
    $fell(rst_pin_oe) ##0 !rst_pin_i [*4];
  endsequence
  AST_POR_HOLD: assert property (por_cnt_r < POR_CYCLES |-> sys_rst_o)
    else $error("reset left before power-up delay");
  AST_POR_END: assert property (por_cnt_r == POR_CYCLES && rst_pin_i |-> ##[0:3] !sys_rst_o)
    else $error("reset kept after power-up delay");
  AST_PIN_HOLD: assert property (sys_rst_o && !rst_pin_i |=> sys_rst_o)
    else $error("reset left while pin low");
  AST_DRIVE: assert property ($rose(rst_pin_oe) |-> rst_pin_oe [*4] ##1 !rst_pin_oe)
    else $error("pin not driven four cycles");
  AST_INTERNAL: assert property (s_rel_hi |-> ##[0:2] !sys_rst_o)
    else $error("internal reset not ended");
  AST_EXTERNAL: assert property (s_rel_lo |=> sys_rst_o && reset_cause_o == RWCM_CAUSE_PIN)
    else $error("external reset not classed");
  AST_VEC: assert property (!sys_rst_o |-> reset_vector_o == vec_exp)
    else $error("vector does not match cause");
  AST_INIT: assert property (sys_rst_o && $past(sys_rst_o) |-> !clock_monitor_en_o && !ext_int_edge_sel_o)
    else $error("control bits not initialized");
  AST_CM_RST: assert property (clock_monitor_en_o && clk_fail_i |-> ##[1:3] sys_rst_o)
    else $error("clock failure gave no reset");
  AST_HALT_RST: assert property (clock_monitor_en_o && halt_i |-> ##[1:3] sys_rst_o)
    else $error("halt with monitor gave no reset");
endmodule : rwcm_chk
bind rwcm_top rwcm_chk #(.POR_CYCLES(POR_CYCLES)) chk_u (.aclk, .aresetn, .rst_pin_i,
  .rst_pin_oe, .special_mode_i, .halt_i, .clk_fail_i, .sys_rst_o, .reset_vector_o,
  .reset_cause_o, .ext_int_edge_sel_o, .clock_monitor_en_o);
`default_nettype wire

// ==== tb/rwcm_ext_model.sv ====
// external reset circuit on the open-drain reset pin
`default_nettype none
module rwcm_ext_model (
  input wire logic hold_low,
  input wire logic dut_oe,
  input wire logic dut_o,
  output logic pin
);
  timeunit 1ns;
  timeprecision 1ns;
  // pull-up wins unless either side pulls low; holding past delay
  assign pin = !(hold_low || (dut_oe && !dut_o));
endmodule : rwcm_ext_model
`default_nettype wire

// ==== tb/tb.sv ====
// self-checking bench for the reset, watchdog and clock monitor block
`default_nettype none
module tb;
  import rwcm_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int POR_N = 8;
  localparam int WDT_N = 16;
  localparam int LIMIT = 20000;
  typedef struct {logic wr; logic [7:0] a; logic [31:0] d; logic [1:0] resp;} rwcm_row_t;
  logic aclk = 1'h0, aresetn = 1'h0, hold_low = 1'h0, special_mode_i = 1'h0;
  logic halt_i = 1'h0, clk_fail_i = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
  logic s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'h1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, reset_cause_o, r;
  logic [31:0] s_axi_rdata, d;
  logic rst_pin_o, rst_pin_oe, sys_rst_o, ext_int_edge_sel_o, clock_monitor_en_o;
  logic [15:0] reset_vector_o;
  wire logic pin_w;
  int mismatches = 0, checks_done = 0, cyc = 0, n, t0;
  rwcm_row_t rows [13] = '{
    '{1'h0, RWCM_OFF_OPTIONS, 32'h0000_0000, RWCM_RESP_OKAY},
    '{1'h0, RWCM_OFF_SETUP, 32'h0000_000f, RWCM_RESP_OKAY},
    '{1'h1, RWCM_OFF_OPTIONS, 32'h0000_0023, RWCM_RESP_OKAY},
    '{1'h0, RWCM_OFF_OPTIONS, 32'h0000_0023, RWCM_RESP_OKAY},
    '{1'h1, RWCM_OFF_OPTIONS, 32'h0000_0000, RWCM_RESP_OKAY},
    '{1'h0, RWCM_OFF_OPTIONS, 32'h0000_0003, RWCM_RESP_OKAY},
    '{1'h1, RWCM_OFF_SETUP, 32'h0000_000b, RWCM_RESP_OKAY},
    '{1'h0, RWCM_OFF_SETUP, 32'h0000_000b, RWCM_RESP_OKAY},
    '{1'h0, RWCM_OFF_STATUS, 32'h0000_0020, RWCM_RESP_OKAY},
    '{1'h1, RWCM_OFF_STATUS, 32'h0000_0000, RWCM_RESP_SLVERR},
    '{1'h0, 8'h14, 32'h0000_0000, RWCM_RESP_SLVERR},
    '{1'h1, RWCM_OFF_TEST, 32'h0000_0001, RWCM_RESP_OKAY},
    '{1'h0, RWCM_OFF_TEST, 32'h0000_0000, RWCM_RESP_OKAY}};
  rwcm_top #(.WDT_BASE_DIV(WDT_N), .POR_CYCLES(POR_N)) dut_u (.aclk, .aresetn,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .rst_pin_i(pin_w), .rst_pin_o, .rst_pin_oe,
    .special_mode_i, .halt_i, .clk_fail_i, .sys_rst_o, .reset_vector_o, .reset_cause_o,
    .ext_int_edge_sel_o, .clock_monitor_en_o);
  rwcm_ext_model ext_u (.hold_low, .dut_oe(rst_pin_oe), .dut_o(rst_pin_o), .pin(pin_w));
  // clock
  initial
  begin
    forever #20 aclk = !aclk;
  end
  // cycle count and hang guard
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == LIMIT)
    begin
      mismatches++;
      print_verdict();
    end
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  task automatic cmpb(input logic ok);
    checks_done++;
    if (ok !== 1'h1)
    begin
      mismatches++;
      $display("MISMATCH t=%0t condition false", $time);
    end
  endtask : cmpb
  task automatic cmp_cause(input logic [1:0] c, input logic [15:0] v);
    cmp({14'h0000, reset_cause_o}, {14'h0000, c});
    cmp({16'h0000, reset_vector_o}, {16'h0000, v});
  endtask : cmp_cause
  // axi4-lite write; handshakes judged from pre-edge levels
  task automatic wr(input logic [7:0] a, input logic [31:0] dat, output logic [1:0] rs);
    logic aw_t, w_t, b_t;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= dat;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do
    begin
      @(negedge aclk);
      aw_t = s_axi_awvalid && s_axi_awready;
      w_t = s_axi_wvalid && s_axi_wready;
      b_t = s_axi_bvalid;
      rs = s_axi_bresp;
      @(posedge aclk);
      if (aw_t) s_axi_awvalid <= 1'h0;
      if (w_t) s_axi_wvalid <= 1'h0;
    end while (!b_t);
    s_axi_bready <= 1'h0;
  endtask : wr
  // axi4-lite read
  task automatic rd(input logic [7:0] a, output logic [31:0] dat, output logic [1:0] rs);
    logic a_t, r_t;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do
    begin
      @(negedge aclk);
      a_t = s_axi_arvalid && s_axi_arready;
      r_t = s_axi_rvalid;
      dat = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge aclk);
      if (a_t) s_axi_arvalid <= 1'h0;
    end while (!r_t);
    s_axi_rready <= 1'h0;
  endtask : rd
  task automatic wait_rst(input logic v, output int cnt);
    cnt = 0;
    do
    begin
      @(negedge aclk);
      cnt++;
    end while (sys_rst_o !== v && cnt < 3000);
  endtask : wait_rst
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : print_verdict
  // main sequence
  initial
  begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    wait_rst(1'h0, n);
    cmpb(n >= POR_N && n <= POR_N + 3);
    cmp_cause(RWCM_CAUSE_POR, RWCM_VEC_NORMAL);
    // second power-up with the pin held low past the delay
    @(posedge aclk);
    aresetn <= 1'h0;
    hold_low <= 1'h1;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (POR_N + 12) @(posedge aclk);
    cmpb(sys_rst_o);
    hold_low <= 1'h0;
    wait_rst(1'h0, n);
    cmpb(n <= 3);
    $display("test power_up done");
    foreach (rows[i])
    begin
      if (rows[i].wr) wr(rows[i].a, rows[i].d, r);
      else rd(rows[i].a, d, r);
      cmp({30'h0000_0000, r}, {30'h0000_0000, rows[i].resp});
      if (!rows[i].wr && rows[i].resp == RWCM_RESP_OKAY) cmp(d, rows[i].d);
    end
    repeat (64 * WDT_N + 100) @(posedge aclk);
    cmpb(!sys_rst_o);
    $display("test registers done");
    hold_low <= 1'h1;
    wait_rst(1'h1, n);
    repeat (12) @(posedge aclk);
    hold_low <= 1'h0;
    wait_rst(1'h0, n);
    wr(RWCM_OFF_OPTIONS, 32'h0000_0003, r);
    cmp_cause(RWCM_CAUSE_PIN, RWCM_VEC_NORMAL);
    rd(RWCM_OFF_STATUS, d, r);
    cmp(d, 32'h0000_0029);
    $display("test pin_reset done");
    repeat (3)
    begin
      repeat (700) @(posedge aclk);
      wr(RWCM_OFF_SERVICE, {24'h00_0000, RWCM_ARM_CODE}, r);
      rd(RWCM_OFF_STATUS, d, r);
      cmp(d, 32'h0000_0039);
      wr(RWCM_OFF_SERVICE, {24'h00_0000, RWCM_CLEAR_CODE}, r);
    end
    t0 = cyc;
    cmpb(!sys_rst_o);
    special_mode_i <= 1'h1;
    wr(RWCM_OFF_SERVICE, {24'h00_0000, RWCM_CLEAR_CODE}, r);
    wr(RWCM_OFF_SERVICE, 32'h0000_0012, r);
    halt_i <= 1'h1;
    repeat (100) @(posedge aclk);
    halt_i <= 1'h0;
    wait_rst(1'h1, n);
    cmpb(cyc - t0 >= 64 * WDT_N + 96 && cyc - t0 <= 64 * WDT_N + 108);
    wait_rst(1'h0, n);
    cmp_cause(RWCM_CAUSE_WDT, RWCM_VEC_WDT & RWCM_VEC_SPECIAL_MASK);
    $display("test watchdog done");
    wr(RWCM_OFF_OPTIONS, 32'h0000_0028, r);
    cmpb(ext_int_edge_sel_o);
    clk_fail_i <= 1'h1;
    wait_rst(1'h1, n);
    cmpb(n <= 4);
    @(posedge aclk);
    clk_fail_i <= 1'h0;
    wait_rst(1'h0, n);
    cmp_cause(RWCM_CAUSE_CLKMON, RWCM_VEC_CLKMON & RWCM_VEC_SPECIAL_MASK);
    cmpb(!clock_monitor_en_o);
    wr(RWCM_OFF_OPTIONS, 32'h0000_0008, r);
    halt_i <= 1'h1;
    wait_rst(1'h1, n);
    cmpb(n <= 4);
    @(posedge aclk);
    halt_i <= 1'h0;
    wait_rst(1'h0, n);
    cmp_cause(RWCM_CAUSE_CLKMON, RWCM_VEC_CLKMON & RWCM_VEC_SPECIAL_MASK);
    $display("test clock_monitor done");
    wr(RWCM_OFF_TEST, 32'h0000_0000, r);
    wait_rst(1'h1, n);
    cmpb(n <= WDT_N + 4);
    wait_rst(1'h0, n);
    cmp_cause(RWCM_CAUSE_WDT, RWCM_VEC_WDT & RWCM_VEC_SPECIAL_MASK);
    $display("test inhibit done");
    // rate codes 01 and 10: timeout of four and sixteen base periods after release
    for (int k = 1; k < 3; k++)
    begin
      t0 = cyc;
      wr(RWCM_OFF_OPTIONS, 32'(k), r);
      wr(RWCM_OFF_TEST, 32'h0000_0000, r);
      wait_rst(1'h1, n);
      cmpb(cyc - t0 == WDT_N * (1 << (2 * k)) + 1);
      wait_rst(1'h0, n);
    end
    $display("test rates done");
    print_verdict();
  end
endmodule : tb
`default_nettype wire
